// ### design/iod_pkg.sv
package iod_pkg;
   // Register byte offsets on the APB slave
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_SFP = 8'h04;
   localparam logic [7:0] REG_BANK = 8'h08;
   localparam logic [7:0] REG_ACC = 8'h0C;
   localparam logic [7:0] REG_FLAGS = 8'h10;
   localparam logic [7:0] REG_OPCODE = 8'h14;
   localparam logic [7:0] REG_EADDR = 8'h18;
   localparam logic [7:0] REG_MPTR = 8'h1C;
   localparam logic [7:0] REG_MDATA = 8'h20;
   // Field positions
   localparam int CTRL_EXT_BIT = 0;
   localparam int EADDR_IDX_BIT = 16;
   localparam int OP_ACCESS_BIT = 8;
   localparam int OP_DEST_BIT = 9;
   // Opcode pattern of the indexed add: 0010 01d0 kkkk kkkk
   localparam logic [5:0] ADD_OPC_HI = 6'h09;
   // Highest operand that is taken as an offset
   localparam logic [7:0] OFFSET_LIMIT = 8'h5F;
   // Upper address nibble of the high half of the access bank
   localparam logic [3:0] ACCESS_HIGH = 4'hF;
   // Reset values
   localparam logic CTRL_RESET = 1'b0;
   localparam logic [11:0] SFP_RESET = 12'h000;
   localparam logic [3:0] BANK_RESET = 4'h0;
   localparam logic [7:0] ACC_RESET = 8'h00;

   // Arithmetic flags after an add
   typedef struct packed {
      logic n;
      logic ov;
      logic z;
      logic dc;
      logic c;
   } iod_flags_type;

   localparam iod_flags_type FLAGS_RESET = 5'h00;
endpackage

// ### design/iod_operand_decode.sv
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Contract
// RULE1: Extended mode reinterprets byte and bit operands
// RULE2: Unextended: a=0 access bank, a=1 banked
// RULE3: Extended, a=0, operand <=5Fh: pointer offset
// RULE4: Operands above 5Fh stay literal addresses
// RULE5: Pointer 00h reproduces original access mapping
// RULE6: Destination bit keeps its normal meaning
// RULE7: Indexed add sums accumulator, sets five flags
// RULE8: Add encoding 0010 01d0; d selects destination
// RULE9: Address is pointer plus zero-extended offset
// RULE10: Indexed add completes in one cycle
module iod_operand_decode #(
   parameter int ADDR_W = 12,
   parameter int DEPTH = 4096
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [ADDR_W-1:0] eff_addr,
   output logic indexed_active,
   output logic add_done
);

   // ==========================================================
   // Register state
   // ==========================================================
   logic ext_enable;
   logic [ADDR_W-1:0] stack_frame_pointer;
   logic [3:0] bank_select_register;
   logic [7:0] acc;
   iod_pkg::iod_flags_type flags;
   logic [ADDR_W-1:0] mem_ptr;
   logic [7:0] data_mem [DEPTH];

   // ==========================================================
   // Bus decode
   // ==========================================================
   logic access_edge;
   logic wr_edge;
   logic exec;
   logic mapped;

   // A transfer finishes on the access cycle where pready is high
   assign access_edge = ce && psel && penable && pready;
   assign wr_edge = access_edge && pwrite;
   assign exec = wr_edge && (paddr == iod_pkg::REG_OPCODE);

   always_comb begin
      case (paddr)
         iod_pkg::REG_CTRL, iod_pkg::REG_SFP, iod_pkg::REG_BANK,
         iod_pkg::REG_ACC, iod_pkg::REG_FLAGS, iod_pkg::REG_OPCODE,
         iod_pkg::REG_EADDR, iod_pkg::REG_MPTR,
         iod_pkg::REG_MDATA: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // ==========================================================
   // Operand decode
   // ==========================================================
   logic [15:0] opcode;
   logic [7:0] op_f;
   logic op_a;
   logic op_d;
   logic low_range;
   logic use_index;
   logic is_add;
   logic [ADDR_W-1:0] idx_addr;
   logic [ADDR_W-1:0] next_eff_addr;

   assign opcode = pwdata[15:0];
   assign op_f = opcode[7:0];
   assign op_a = opcode[iod_pkg::OP_ACCESS_BIT];
   assign op_d = opcode[iod_pkg::OP_DEST_BIT];
   assign low_range = (op_f <= iod_pkg::OFFSET_LIMIT); // [RULE4]
   // Only the access-bank form is ever reinterpreted
   assign use_index = ext_enable && !op_a && low_range; // [RULE1] [RULE3]
   assign is_add = (opcode[15:10] == iod_pkg::ADD_OPC_HI)
      && !opcode[iod_pkg::OP_ACCESS_BIT]; // [RULE8]
   // Pointer is only read here, never bumped by an access
   assign idx_addr = stack_frame_pointer
      + {{(ADDR_W-8){1'b0}}, op_f}; // [RULE9]

   // Effective address selection
   always_comb begin
      if (use_index) begin
         next_eff_addr = idx_addr; // [RULE3] [RULE5]
      end else if (op_a) begin
         next_eff_addr = {bank_select_register, op_f}; // [RULE2]
      end else if (low_range) begin
         next_eff_addr = {4'h0, op_f}; // [RULE2]
      end else begin
         next_eff_addr = {iod_pkg::ACCESS_HIGH, op_f}; // [RULE4]
      end
   end

   // ==========================================================
   // Indexed add datapath
   // ==========================================================
   logic [7:0] operand;
   logic [8:0] sum;
   logic [4:0] low_sum;
   iod_pkg::iod_flags_type next_flags;

   assign operand = data_mem[next_eff_addr];
   assign sum = {1'b0, acc} + {1'b0, operand}; // [RULE7]
   assign low_sum = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};

   // Flags follow from the same sum that is written back
   always_comb begin
      next_flags.c = sum[8];
      next_flags.dc = low_sum[4];
      next_flags.z = (sum[7:0] == 8'h00);
      next_flags.n = sum[7];
      next_flags.ov = (acc[7] == operand[7]) && (sum[7] != acc[7]);
   end

   // ==========================================================
   // Software-written state
   // ==========================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_enable <= iod_pkg::CTRL_RESET;
         stack_frame_pointer <= iod_pkg::SFP_RESET;
         bank_select_register <= iod_pkg::BANK_RESET;
         mem_ptr <= '0;
      end else if (wr_edge) begin
         case (paddr)
            iod_pkg::REG_CTRL: ext_enable <= pwdata[iod_pkg::CTRL_EXT_BIT];
            iod_pkg::REG_SFP: stack_frame_pointer <= pwdata[ADDR_W-1:0];
            iod_pkg::REG_BANK: bank_select_register <= pwdata[3:0];
            iod_pkg::REG_MPTR: mem_ptr <= pwdata[ADDR_W-1:0];
            default: ;
         endcase
      end
   end

   // Accumulator: software write or add result with d=0
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc <= iod_pkg::ACC_RESET;
      end else if (exec && is_add && !op_d) begin
         acc <= sum[7:0]; // [RULE6] [RULE8]
      end else if (wr_edge && paddr == iod_pkg::REG_ACC) begin
         acc <= pwdata[7:0];
      end
   end

   // Flags update on every add, whatever the destination
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= iod_pkg::FLAGS_RESET;
      end else if (exec && is_add) begin
         flags <= next_flags; // [RULE7]
      end else if (wr_edge && paddr == iod_pkg::REG_FLAGS) begin
         flags <= pwdata[4:0];
      end
   end

   // Data memory has no reset; it is a plain array
   always_ff @(posedge pclk) begin
      if (exec && is_add && op_d) begin
         data_mem[next_eff_addr] <= sum[7:0]; // [RULE6] [RULE8]
      end else if (wr_edge && paddr == iod_pkg::REG_MDATA) begin
         data_mem[mem_ptr] <= pwdata[7:0];
      end
   end

   // Decode results, whole instruction in one clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eff_addr <= '0;
         indexed_active <= 1'b0;
         add_done <= 1'b0;
      end else if (ce) begin
         add_done <= exec && is_add; // [RULE10]
         if (exec) begin
            eff_addr <= next_eff_addr;
            indexed_active <= use_index; // [RULE1]
         end
      end
   end

   // ==========================================================
   // APB answer
   // ==========================================================
   // Answer a setup, or an access whose setup was missed with ce low;
   // without the second case a stalled setup would hang the bus
   logic answer;
   assign answer = psel && !(penable && pready);

   // Read data is captured with the answer so prdata is a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= answer;
         pslverr <= answer && !mapped;
         if (answer) begin
            case (paddr)
               iod_pkg::REG_CTRL: prdata <= {31'h0, ext_enable};
               iod_pkg::REG_SFP: prdata <= {{(32-ADDR_W){1'b0}},
                  stack_frame_pointer};
               iod_pkg::REG_BANK: prdata <= {28'h0, bank_select_register};
               iod_pkg::REG_ACC: prdata <= {24'h0, acc};
               iod_pkg::REG_FLAGS: prdata <= {27'h0, flags};
               iod_pkg::REG_EADDR: prdata <= {15'h0, indexed_active,
                  {(16-ADDR_W){1'b0}}, eff_addr};
               iod_pkg::REG_MPTR: prdata <= {{(32-ADDR_W){1'b0}}, mem_ptr};
               iod_pkg::REG_MDATA: prdata <= {24'h0, data_mem[mem_ptr]};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   index_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
      exec && ext_enable && !op_a && low_range |=> indexed_active) // [RULE1]
      else $error("indexed mode not taken");
   banked_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
      exec && !ext_enable && op_a
      |=> eff_addr == {$past(bank_select_register), $past(op_f)}) // [RULE2]
      else $error("banked address wrong");
   access_low_a: assert property (@(posedge pclk) disable iff (!presetn)
      exec && !ext_enable && !op_a && low_range
      |=> eff_addr == {4'h0, $past(op_f)} && !indexed_active) // [RULE2]
      else $error("access bank address wrong");
   offset_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
      exec && use_index |=> eff_addr == $past(idx_addr)
      && stack_frame_pointer == $past(stack_frame_pointer)) // [RULE3]
      else $error("offset address wrong");
   high_literal_a: assert property (@(posedge pclk) disable iff (!presetn)
      exec && ext_enable && !op_a && !low_range
      |=> eff_addr == {iod_pkg::ACCESS_HIGH, $past(op_f)}
      && !indexed_active) // [RULE4]
      else $error("high operand was indexed");
   zero_ptr_a: assert property (@(posedge pclk) disable iff (!presetn)
      exec && !op_a && low_range && stack_frame_pointer == '0
      |=> eff_addr == {4'h0, $past(op_f)}) // [RULE5]
      else $error("zero pointer mapping differs");
   dest_file_a: assert property (@(posedge pclk) disable iff (!presetn)
      exec && is_add && op_d |=> acc == $past(acc)) // [RULE6]
      else $error("accumulator changed for d=1");
   add_result_a: assert property (@(posedge pclk) disable iff (!presetn)
      exec && is_add && !op_d |=> acc == $past(sum[7:0])) // [RULE8]
      else $error("add result not in accumulator");
   add_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
      exec && is_add |=> flags.c == $past(sum[8])
      && flags.z == ($past(sum[7:0]) == 8'h00)
      && flags.n == $past(sum[7])) // [RULE7]
      else $error("add flags wrong");
   offset_sum_a: assert property (@(posedge pclk) disable iff (!presetn)
      exec && use_index |=> eff_addr - stack_frame_pointer
      == {{(ADDR_W-8){1'b0}}, $past(op_f)}) // [RULE9]
      else $error("offset not zero extended");
   one_cycle_a: assert property (@(posedge pclk) disable iff (!presetn)
      exec && is_add && ce
      |=> add_done ##1 (!add_done || !$past(ce))) // [RULE10]
      else $error("add not single cycle");

endmodule

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
   logic pclk, presetn, ce, psel, penable, pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, indexed_active, add_done, err;
   logic [11:0] eff_addr, sfp, addr;
   logic [3:0] bank;
   logic ext, d;
   logic [15:0] op;
   logic [7:0] w, m, k;
   logic [8:0] s;
   iod_pkg::iod_flags_type fl;
   int miscompares, check_count;
   logic [7:0] regs [7];

   iod_operand_decode #(.ADDR_W(12), .DEPTH(4096)) dut (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .eff_addr(eff_addr), .indexed_active(indexed_active),
      .add_done(add_done));

   // ==========================================
   // Clock and reporting
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // ==========================================
   // APB master: request held until pready is seen at the edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] dat);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= dat;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // Wait for pready at a rising edge; the answer is taken there
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         miscompares++;
         wrap_up();
      end else begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   // ==========================================
   // Reference address model, written independently of the design
   function automatic logic [11:0] ea_of(input logic [15:0] o);
      if (ext && !o[8] && o[7:0] <= 8'h5F) return sfp + {4'h0, o[7:0]};
      if (o[8]) return {bank, o[7:0]};
      return (o[7:0] <= 8'h5F) ? {4'h0, o[7:0]} : {4'hF, o[7:0]};
   endfunction

   // Execute one opcode and look at the outputs in the cycle after
   task automatic run(input logic [15:0] o, input logic is_add);
      logic ind;
      ind = ext && !o[8] && o[7:0] <= 8'h5F;
      apb(1'b1, iod_pkg::REG_OPCODE, {16'h0, o});
      @(negedge pclk);
      chk({18'h0, add_done, indexed_active, eff_addr},
          {18'h0, is_add, ind, ea_of(o)});
      rchk(iod_pkg::REG_EADDR, {15'h0, ind, 4'h0, ea_of(o)});
   endtask

   task automatic setup_mode;
      apb(1'b1, iod_pkg::REG_CTRL, {31'h0, ext});
      apb(1'b1, iod_pkg::REG_SFP, {20'h0, sfp});
      apb(1'b1, iod_pkg::REG_BANK, {28'h0, bank});
   endtask

   // ==========================================
   // Main sequence
   initial begin
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      regs = '{iod_pkg::REG_CTRL, iod_pkg::REG_SFP, iod_pkg::REG_BANK,
               iod_pkg::REG_ACC, iod_pkg::REG_FLAGS, iod_pkg::REG_OPCODE,
               iod_pkg::REG_EADDR};
      void'($urandom(32'hE36DFB07));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      chk({18'h0, add_done, indexed_active, eff_addr}, 32'h0);
      for (int i = 0; i < 7; i++) rchk(regs[i], 32'h0);
      // Unmapped place: refused, write dropped, reads zero
      apb(1'b1, 8'h40, 32'hFFFF_FFFF);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 8'h40, 32'h0);
      chk({err, rd[30:0]}, 32'h8000_0000);
      // Clock enable low through the setup: access stalls, then lands
      ce <= 1'b0;
      fork
         apb(1'b1, iod_pkg::REG_ACC, 32'h0000_005A);
         begin
            repeat (4) @(posedge pclk);
            chk({31'h0, pready}, 32'h0);
            ce <= 1'b1;
         end
      join
      rchk(iod_pkg::REG_ACC, 32'h0000_005A);
      // Address decode across modes, access bits and the 5Fh edge
      for (int i = 0; i < 48; i++) begin
         ext = i[0];
         bank = 4'($urandom);
         sfp = (i < 8) ? 12'h000 : 12'($urandom);
         op = 16'($urandom);
         case (i % 4)
            0: op[7:0] = 8'h5F;
            1: op[7:0] = 8'h60;
            2: op[7:0] = 8'h00;
            default: op[7:0] = 8'($urandom);
         endcase
         if (op[15:10] == iod_pkg::ADD_OPC_HI) op[15] = 1'b1;
         setup_mode();
         run(op, 1'b0);
      end
      // Indexed add with both destinations, flags and boundary offset
      for (int i = 0; i < 16; i++) begin
         ext = (i < 12);
         sfp = 12'($urandom);
         bank = 4'($urandom);
         k = 8'($urandom_range(95, 0));
         w = 8'($urandom);
         m = 8'($urandom);
         d = 1'($urandom);
         if (i == 0) begin
            sfp = 12'hA00;
            k = 8'h2C;
            w = 8'h17;
            m = 8'h20;
            d = 1'b0;
         end
         if (i == 1) k = 8'h5F;
         op = {iod_pkg::ADD_OPC_HI, d, 1'b0, k};
         addr = ea_of(op);
         setup_mode();
         apb(1'b1, iod_pkg::REG_MPTR, {20'h0, addr});
         apb(1'b1, iod_pkg::REG_MDATA, {24'h0, m});
         apb(1'b1, iod_pkg::REG_ACC, {24'h0, w});
         run(op, 1'b1);
         s = {1'b0, w} + {1'b0, m};
         fl.n = s[7];
         fl.ov = (w[7] == m[7]) && (s[7] != w[7]);
         fl.z = (s[7:0] == 8'h00);
         fl.dc = ({1'b0, w[3:0]} + {1'b0, m[3:0]}) > 5'h0F;
         fl.c = s[8];
         rchk(iod_pkg::REG_ACC, {24'h0, d ? w : s[7:0]});
         rchk(iod_pkg::REG_FLAGS, {27'h0, fl});
         apb(1'b1, iod_pkg::REG_MPTR, {20'h0, addr});
         rchk(iod_pkg::REG_MDATA, {24'h0, d ? s[7:0] : m});
      end
      wrap_up();
   end
endmodule
